// File: lps_conv_timer.sv
// Proximity conversion and sleep sequencer
`timescale 1ns/1ps
module lps_conv_timer
   import lps_pkg::*;
#(
   parameter int CONV_CYC = CONV_CYC_DEF,
   parameter int UNIT_CYC = UNIT_CYC_DEF
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Control
   input  wire logic       enable_i,
   input  wire logic [2:0] sleep_sel_i,
   // Status
   output logic            convert_o,
   output logic            done_o
);
   typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_SLEEP} lps_tmr_t;
   lps_tmr_t    state_ff;
   logic [24:0] cnt_ff;
   logic [6:0]  units_ff;

   // Sequencing; sleep is counted in 12.5 ms units to keep one short counter
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff <= ST_IDLE;
         cnt_ff   <= 25'h000_0000;
         units_ff <= 7'h00;
      end else if (!enable_i) begin
         state_ff <= ST_IDLE;
         cnt_ff   <= 25'h000_0000;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               state_ff <= ST_CONV;
            end
            ST_CONV: begin
               if (cnt_ff == 25'(CONV_CYC - 1)) begin
                  cnt_ff   <= 25'h000_0000;
                  units_ff <= sleep_units(sleep_sel_i);
                  state_ff <= (sleep_units(sleep_sel_i) == 7'h00) ? ST_CONV : ST_SLEEP;
               end else begin
                  cnt_ff <= cnt_ff + 25'h000_0001;
               end
            end
            ST_SLEEP: begin
               if (cnt_ff == 25'(UNIT_CYC - 1)) begin
                  cnt_ff   <= 25'h000_0000;
                  units_ff <= units_ff - 7'h01;
                  if (units_ff == 7'h01) begin
                     state_ff <= ST_CONV;
                  end
               end else begin
                  cnt_ff <= cnt_ff + 25'h000_0001;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // End-of-conversion strobe, one cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done_o <= 1'b0;
      end else begin
         done_o <= enable_i && state_ff == ST_CONV && cnt_ff == 25'(CONV_CYC - 1);
      end
   end

   assign convert_o = (state_ff == ST_CONV);

   chk_done_after_conv: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      done_o |-> $past(convert_o)) else $error("done without a conversion");
   cov_sleep_entered: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      state_ff == ST_CONV ##1 state_ff == ST_SLEEP);
endmodule : lps_conv_timer

// File: lps_ctrl.sv
// Register file, result capture and interrupt logic of the light/proximity sensor
`timescale 1ns/1ps
module lps_ctrl
   import lps_pkg::*;
#(
   parameter int         CONV_CYC = CONV_CYC_DEF,
   parameter int         UNIT_CYC = UNIT_CYC_DEF,
   parameter logic [7:0] PART_ID  = 8'h5A // Arbitrary identity value
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Register port from the serial engine
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic [7:0]  reg_wdata_i,
   output logic      [7:0]  reg_rdata_o,
   // Proximity front end
   input  wire logic [7:0]  near_data_i,
   output logic             near_convert_o,
   output logic             led_drive_sel_o,
   // Light front end
   input  wire logic [11:0] vis_data_i,
   input  wire logic [11:0] ir_data_i,
   input  wire logic        light_valid_i,
   output logic             light_sense_on_o,
   output logic             light_full_scale_sel_o,
   output logic             light_source_sel_o,
   // Open-drain interrupt pin
   input  wire logic        irq_pin_i,
   output logic             irq_pin_o,
   output logic             irq_pin_oe_o
);
   logic [7:0]  cfg_ff;
   logic [6:0]  irq_ctl_ff;
   logic        light_flag_ff;
   logic        near_flag_ff;
   logic [7:0]  near_low_limit_ff;
   logic [7:0]  near_high_limit_ff;
   logic [7:0]  lth_lo_ff;
   logic [7:0]  lth_nib_ff;
   logic [7:0]  lth_hi_ff;
   logic [7:0]  near_result_ff;
   logic [11:0] light_result_ff;
   logic [7:0]  rdata_ff;
   logic [11:0] light_low_limit;
   logic [11:0] light_high_limit;
   logic [11:0] light_sample;
   logic        irq_wr;
   logic        near_done;
   logic        light_take;
   logic        light_out;
   logic        light_fire;
   logic        near_hi_fire;
   logic        near_lo_fire;
   logic        irq_active;
   logic        unused_pin;

   assign irq_wr     = reg_wr_i && reg_addr_i == ADDR_IRQ;
   assign light_take = light_valid_i && light_sense_on_o;
   assign unused_pin = irq_pin_i;

   // Host-writable configuration and thresholds
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_ff             <= CFG_RST;
         near_low_limit_ff  <= NLOW_RST;
         near_high_limit_ff <= NHIGH_RST;
         lth_lo_ff          <= LTH_LO_RST;
         lth_nib_ff         <= LTH_NIB_RST;
         lth_hi_ff          <= LTH_HI_RST;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            ADDR_CFG:     cfg_ff             <= reg_wdata_i;
            ADDR_NLOW:    near_low_limit_ff  <= reg_wdata_i;
            ADDR_NHIGH:   near_high_limit_ff <= reg_wdata_i;
            ADDR_LTH_LO:  lth_lo_ff          <= reg_wdata_i;
            ADDR_LTH_NIB: lth_nib_ff         <= reg_wdata_i;
            ADDR_LTH_HI:  lth_hi_ff          <= reg_wdata_i;
            default: begin
            end
         endcase
      end
   end

   // Configuration bits straight to the front ends
   assign light_source_sel_o     = cfg_ff[CFG_SRC_BIT];
   assign light_full_scale_sel_o = cfg_ff[CFG_RANGE_BIT];
   assign light_sense_on_o       = cfg_ff[CFG_LIGHT_BIT];
   assign led_drive_sel_o        = cfg_ff[CFG_LED_BIT];

   // Twelve-bit light window from three byte registers
   assign light_low_limit  = {lth_nib_ff[3:0], lth_lo_ff};
   assign light_high_limit = {lth_hi_ff, lth_nib_ff[7:4]};
   assign light_sample     = light_source_sel_o ? ir_data_i : vis_data_i;
   assign light_out = light_sample <= light_low_limit || light_sample >= light_high_limit;

   // Proximity conversion pacing
   lps_conv_timer #(
      .CONV_CYC (CONV_CYC),
      .UNIT_CYC (UNIT_CYC)
   ) u_timer (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .enable_i    (cfg_ff[CFG_NEAR_BIT]),
      .sleep_sel_i (cfg_ff[CFG_SLP_LSB+:3]),
      .convert_o   (near_convert_o),
      .done_o      (near_done)
   );

   // Results are captured only while their sensor is on
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         near_result_ff  <= ZERO8;
         light_result_ff <= {ZERO8[3:0], ZERO8};
      end else begin
         if (near_done) begin
            near_result_ff <= near_data_i;
         end
         if (light_take) begin
            light_result_ff <= light_sample;
         end
      end
   end

   // Streak counters for the light window and both proximity limits
   lps_persist u_light_per (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .take_i  (light_take),
      .hit_i   (light_out),
      .sel_i   (irq_ctl_ff[IRQ_LPER_LSB+:2]),
      .fire_o  (light_fire)
   );
   lps_persist u_near_hi (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .take_i  (near_done),
      .hit_i   (near_data_i >= near_high_limit_ff),
      .sel_i   (irq_ctl_ff[IRQ_NPER_LSB+:2]),
      .fire_o  (near_hi_fire)
   );
   lps_persist u_near_lo (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .take_i  (near_done),
      .hit_i   (near_data_i <= near_low_limit_ff),
      .sel_i   (irq_ctl_ff[IRQ_NPER_LSB+:2]),
      .fire_o  (near_lo_fire)
   );

   // Interrupt control fields, stored without the flags; bit 4 is never kept
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_ctl_ff <= IRQ_RST[6:0];
      end else if (irq_wr) begin
         irq_ctl_ff <= {reg_wdata_i[6:5], 1'b0, 1'b0, reg_wdata_i[2:0]};
      end
   end

   // Flags: hardware set wins over a host clear; host writes of 1 do nothing
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         light_flag_ff <= 1'b0;
         near_flag_ff  <= 1'b0;
      end else begin
         light_flag_ff <= light_fire ||
            (light_flag_ff && !(irq_wr && !reg_wdata_i[IRQ_LFLAG_BIT]));
         near_flag_ff  <= near_hi_fire || (near_flag_ff && !near_lo_fire &&
            !(irq_wr && !reg_wdata_i[IRQ_NFLAG_BIT]));
      end
   end

   // Combine flags; pin is only ever pulled low
   assign irq_active = irq_ctl_ff[IRQ_COMB_BIT] ? (light_flag_ff && near_flag_ff)
                                                : (light_flag_ff || near_flag_ff);
   assign irq_pin_o    = 1'b0;
   assign irq_pin_oe_o = irq_active;

   // Read data registered; unmapped addresses read zero
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_ff <= ZERO8;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            ADDR_PART_ID: rdata_ff <= PART_ID;
            ADDR_CFG:     rdata_ff <= cfg_ff;
            ADDR_IRQ:     rdata_ff <= {near_flag_ff, irq_ctl_ff[6:5], 1'b0,
                                       light_flag_ff, irq_ctl_ff[2:0]};
            ADDR_NLOW:    rdata_ff <= near_low_limit_ff;
            ADDR_NHIGH:   rdata_ff <= near_high_limit_ff;
            ADDR_LTH_LO:  rdata_ff <= lth_lo_ff;
            ADDR_LTH_NIB: rdata_ff <= lth_nib_ff;
            ADDR_LTH_HI:  rdata_ff <= lth_hi_ff;
            ADDR_NRES:    rdata_ff <= near_result_ff;
            ADDR_LRES_LO: rdata_ff <= light_result_ff[7:0];
            ADDR_LRES_HI: rdata_ff <= {ZERO8[3:0], light_result_ff[11:8]};
            default:      rdata_ff <= ZERO8;
         endcase
      end
   end
   assign reg_rdata_o = rdata_ff;

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   chk_src_visible: assert property (
      light_take && !light_source_sel_o |=> light_result_ff == $past(vis_data_i))
      else $error("visible sample not captured");
   chk_src_ir: assert property (
      light_take && light_source_sel_o |=> light_result_ff == $past(ir_data_i))
      else $error("infrared sample not captured");
   chk_range_write: assert property (
      reg_wr_i && reg_addr_i == ADDR_CFG |=> light_full_scale_sel_o == $past(reg_wdata_i[1]))
      else $error("range select did not follow write");
   chk_light_off: assert property (
      !light_sense_on_o |=> $stable(light_result_ff))
      else $error("light result moved while off");
   chk_led_write: assert property (
      reg_wr_i && reg_addr_i == ADDR_CFG |=> led_drive_sel_o == $past(reg_wdata_i[3]))
      else $error("LED drive did not follow write");
   chk_near_off: assert property (
      !cfg_ff[CFG_NEAR_BIT] ##1 !cfg_ff[CFG_NEAR_BIT] |-> !near_convert_o && !near_done)
      else $error("conversion while proximity off");
   chk_and_mode: assert property (
      irq_ctl_ff[IRQ_COMB_BIT] && !(light_flag_ff && near_flag_ff) |-> !irq_pin_oe_o)
      else $error("pin pulled low without both flags");
   chk_or_mode: assert property (
      !irq_ctl_ff[IRQ_COMB_BIT] && light_flag_ff |-> irq_pin_oe_o && !irq_pin_o)
      else $error("pin released with a flag set");
   chk_flag_clear: assert property (
      irq_wr && reg_wdata_i == ZERO8 && !light_fire |=> !light_flag_ff)
      else $error("light flag not cleared by write");
   chk_flag_one_ign: assert property (
      irq_wr && reg_wdata_i[IRQ_NFLAG_BIT] && !near_flag_ff && !near_hi_fire |=> !near_flag_ff)
      else $error("write of one set the near flag");
   chk_set_wins: assert property (
      light_fire |=> light_flag_ff)
      else $error("light event lost");
   chk_near_clear: assert property (
      near_lo_fire && !near_hi_fire |=> !near_flag_ff)
      else $error("near flag not cleared by low streak");
   chk_near_set: assert property (
      near_hi_fire |=> near_flag_ff)
      else $error("near event lost");
   chk_light_one_ign: assert property (
      irq_wr && reg_wdata_i[IRQ_LFLAG_BIT] && !light_flag_ff && !light_fire |=> !light_flag_ff)
      else $error("write of one set the light flag");
   chk_fields_update: assert property (
      irq_wr |=> irq_ctl_ff[IRQ_LPER_LSB+:2] == $past(reg_wdata_i[IRQ_LPER_LSB+:2])
              && irq_ctl_ff[IRQ_NPER_LSB+:2] == $past(reg_wdata_i[IRQ_NPER_LSB+:2])
              && irq_ctl_ff[IRQ_COMB_BIT] == $past(reg_wdata_i[IRQ_COMB_BIT]))
      else $error("interrupt fields did not follow write");
   // Reserved bit sits just above the light flag
   chk_bit4_reads_zero: assert property (
      reg_rd_i && reg_addr_i == ADDR_IRQ |=> !reg_rdata_o[IRQ_LFLAG_BIT+1])
      else $error("reserved interrupt bit read as one");
   chk_pin_released: assert property (
      !light_flag_ff && !near_flag_ff |-> !irq_pin_oe_o)
      else $error("pin pulled low with no flag");
   chk_lo_limit_write: assert property (
      reg_wr_i && reg_addr_i == ADDR_LTH_LO |=> light_low_limit[7:0] == $past(reg_wdata_i))
      else $error("low limit byte did not follow write");
   chk_hi_limit_write: assert property (
      reg_wr_i && reg_addr_i == ADDR_LTH_HI |=> light_high_limit[11:4] == $past(reg_wdata_i))
      else $error("high limit byte did not follow write");

   cov_light_irq: cover property (light_fire ##1 irq_pin_oe_o);
   cov_near_cycle: cover property (near_hi_fire ##[1:1000] near_lo_fire);
   cov_and_fire: cover property (irq_ctl_ff[IRQ_COMB_BIT] && irq_pin_oe_o);
endmodule : lps_ctrl

// File: lps_host_model.sv
// Host register master standing in for the serial engine
`timescale 1ns/1ps
module lps_host_model (
   // Clock
   input  wire logic       clk_i,
   // Register port
   output logic      [7:0] reg_addr_o,
   output logic            reg_wr_o,
   output logic            reg_rd_o,
   output logic      [7:0] reg_wdata_o,
   input  wire logic [7:0] reg_rdata_i
);
   // Idle bus at time zero
   initial begin
      reg_addr_o  = 8'h01;
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
      reg_wdata_o = 8'h00;
   end

   // One-cycle write strobe; released lines show the inverse so stale data cannot pass
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      if (a != 8'h00) begin
         @(posedge clk_i);
         #1;
         reg_addr_o  = a;
         reg_wdata_o = d;
         reg_wr_o    = 1'b1;
         @(posedge clk_i);
         #1;
         reg_wr_o    = 1'b0;
         reg_addr_o  = ~a;
         reg_wdata_o = ~d;
      end
   endtask : wr

   // One-cycle read strobe; data is valid after the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      d = 8'h00;
      if (a != 8'h00) begin
         @(posedge clk_i);
         #1;
         reg_addr_o = a;
         reg_rd_o   = 1'b1;
         @(posedge clk_i);
         #1;
         reg_rd_o   = 1'b0;
         reg_addr_o = ~a;
         d          = reg_rdata_i;
      end
   endtask : rd
endmodule : lps_host_model

// File: lps_persist.sv
// Consecutive-hit counter that fires once the selected count is reached
`timescale 1ns/1ps
module lps_persist
   import lps_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Sample stream
   input  wire logic       take_i,
   input  wire logic       hit_i,
   input  wire logic [1:0] sel_i,
   // Result
   output logic            fire_o
);
   logic [4:0] cnt_ff;
   logic [4:0] nxt_cnt;

   // Saturate at the largest count so a long streak keeps firing
   assign nxt_cnt = (cnt_ff == persist_n(2'h3)) ? cnt_ff : cnt_ff + 5'h01;

   // A miss restarts the streak
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_ff <= 5'h00;
      end else if (take_i) begin
         cnt_ff <= hit_i ? nxt_cnt : 5'h00;
      end
   end

   assign fire_o = take_i && hit_i && (nxt_cnt >= persist_n(sel_i));

   chk_fire_streak: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      fire_o && sel_i == 2'h1 |-> cnt_ff >= 5'h03) else $error("fired before four hits");
endmodule : lps_persist

// File: lps_pkg.sv
// Constants, field layout and decode helpers for the light/proximity control block
// Functional notes
// - Light result holds visible data when source select is 0 and infrared data when it is 1.
// - Config bit 1 picks the light full scale, 0 for 200 lux and 1 for 3200 lux.
// - Config bit 2 switches light and infrared sensing off at 0 and on at 1.
// - Config bit 3 picks the LED sink pulse, 0 for 110 mA and 1 for 220 mA.
// - Config bits 6:4 pick the proximity sleep of 800/400/200/100/75/50/12.5 ms, or none for code 7.
// - With proximity on, a 0.54 ms conversion and the chosen sleep repeat; default sleep is 800 ms.
// - Proximity sensing runs only while config bit 7 is 1, which is off at reset.
// - Config and interrupt registers reset to 0x00.
// - Interrupt bit 0 combines the two flags by OR when 0 and by AND when 1.
// - The open-drain interrupt pin is pulled low while the chosen combination is true, else released.
// - A host write of 0 to a flag clears it and releases the pin accordingly.
// - Interrupt register is near flag 7, near persistence 6:5, zero 4, light flag 3, light persistence 2:1, combine 0.
// - Light thresholds are twelve bits, low from the shared low nibble and high from the top register.
// - Light flag sets after 1, 4, 8 or 16 consecutive results outside the window.
// - Near flag sets after N results at or above the high limit and clears after N at or below the low one.
package lps_pkg;
   // Register addresses
   localparam logic [7:0] ADDR_PART_ID = 8'h00;
   localparam logic [7:0] ADDR_CFG     = 8'h01;
   localparam logic [7:0] ADDR_IRQ     = 8'h02;
   localparam logic [7:0] ADDR_NLOW    = 8'h03;
   localparam logic [7:0] ADDR_NHIGH   = 8'h04;
   localparam logic [7:0] ADDR_LTH_LO  = 8'h05;
   localparam logic [7:0] ADDR_LTH_NIB = 8'h06;
   localparam logic [7:0] ADDR_LTH_HI  = 8'h07;
   localparam logic [7:0] ADDR_NRES    = 8'h08;
   localparam logic [7:0] ADDR_LRES_LO = 8'h09;
   localparam logic [7:0] ADDR_LRES_HI = 8'h0A;
   // Reset values
   localparam logic [7:0] CFG_RST      = 8'h00;
   localparam logic [7:0] IRQ_RST      = 8'h00;
   localparam logic [7:0] NLOW_RST     = 8'h00;
   localparam logic [7:0] NHIGH_RST    = 8'hFF;
   localparam logic [7:0] LTH_LO_RST   = 8'h00;
   localparam logic [7:0] LTH_NIB_RST  = 8'hF0;
   localparam logic [7:0] LTH_HI_RST   = 8'hFF;
   localparam logic [7:0] ZERO8        = 8'h00;
   // Config fields
   localparam int CFG_SRC_BIT   = 0;
   localparam int CFG_RANGE_BIT = 1;
   localparam int CFG_LIGHT_BIT = 2;
   localparam int CFG_LED_BIT   = 3;
   localparam int CFG_SLP_LSB   = 4;
   localparam int CFG_NEAR_BIT  = 7;
   // Interrupt fields
   localparam int IRQ_COMB_BIT  = 0;
   localparam int IRQ_LPER_LSB  = 1;
   localparam int IRQ_LFLAG_BIT = 3;
   localparam int IRQ_NPER_LSB  = 5;
   localparam int IRQ_NFLAG_BIT = 7;
   // Timing, figures as printed
   localparam int CLK_PERIOD_NS = 40;
   localparam int CONV_TIME_NS  = 540000;
   localparam int SLEEP_UNIT_NS = 12500000;
   localparam int CONV_CYC_DEF  = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int UNIT_CYC_DEF  = SLEEP_UNIT_NS / CLK_PERIOD_NS;

   // Consecutive results needed for each persistence code
   function automatic logic [4:0] persist_n(input logic [1:0] sel);
      case (sel)
         2'h0:    persist_n = 5'h01;
         2'h1:    persist_n = 5'h04;
         2'h2:    persist_n = 5'h08;
         default: persist_n = 5'h10;
      endcase
   endfunction : persist_n

   // Sleep length in 12.5 ms units; zero means back-to-back conversions
   function automatic logic [6:0] sleep_units(input logic [2:0] code);
      case (code)
         3'h0:    sleep_units = 7'h40;
         3'h1:    sleep_units = 7'h20;
         3'h2:    sleep_units = 7'h10;
         3'h3:    sleep_units = 7'h08;
         3'h4:    sleep_units = 7'h06;
         3'h5:    sleep_units = 7'h04;
         3'h6:    sleep_units = 7'h01;
         default: sleep_units = 7'h00;
      endcase
   endfunction : sleep_units
endpackage : lps_pkg

// File: tb_top.sv
// Self-checking bench for the light/proximity control block
`timescale 1ns/1ps
module tb_top
   import lps_pkg::*;
;
   localparam int CONV_T = 3;
   localparam int UNIT_T = 2;
   logic        clk_i;
   logic        rst_n_i;
   logic [7:0]  reg_addr;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;
   logic [7:0]  near_data;
   logic        near_convert;
   logic        led_drive_sel;
   logic [11:0] vis_data;
   logic [11:0] ir_data;
   logic        light_valid;
   logic        light_sense_on;
   logic        light_full_scale_sel;
   logic        light_source_sel;
   logic        irq_pin;
   logic        irq_pin_oe;
   wire         irq_line;
   int          n_errors;
   int          total_checks;
   int          n;
   int          slp[7]  = '{64, 32, 16, 8, 6, 4, 1}; // Sleep in 12.5 ms units
   logic [7:0]  ra[10]  = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A};
   logic [7:0]  rv[10]  = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hF0, 8'hFF, 8'h00, 8'h00, 8'h00};

   // Open-drain line with pull-up
   assign irq_line = irq_pin_oe ? irq_pin : 1'b1;

   lps_ctrl #(.CONV_CYC(CONV_T), .UNIT_CYC(UNIT_T)) lps_ctrl_i (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
      .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .near_data_i(near_data),
      .near_convert_o(near_convert), .led_drive_sel_o(led_drive_sel), .vis_data_i(vis_data),
      .ir_data_i(ir_data), .light_valid_i(light_valid), .light_sense_on_o(light_sense_on),
      .light_full_scale_sel_o(light_full_scale_sel), .light_source_sel_o(light_source_sel),
      .irq_pin_i(irq_line), .irq_pin_o(irq_pin), .irq_pin_oe_o(irq_pin_oe));

   lps_host_model lps_host_model_i (
      .clk_i(clk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
      .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));

   // 25 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      lps_host_model_i.rd(a, d);
      chk({4'h0, d}, {4'h0, e});
   endtask : rchk

   // One-cycle light sample; released data goes to its inverse
   task automatic lsamp(input logic [11:0] v, input logic [11:0] r);
      @(posedge clk_i);
      #1;
      vis_data    = v;
      ir_data     = r;
      light_valid = 1'b1;
      @(posedge clk_i);
      #1;
      light_valid = 1'b0;
      vis_data    = ~v;
      ir_data     = ~r;
   endtask : lsamp

   // Cycles the convert output stays at one level, capped so a stuck output cannot hang
   task automatic run_len(input logic lvl, output int k);
      k = 0;
      while (near_convert === lvl && k < 200) begin
         k++;
         @(posedge clk_i);
         #2;
      end
   endtask : run_len

   // Returns just after the edge that takes the result, one cycle after convert falls
   task automatic conv(input int cnt);
      int k;
      repeat (cnt) begin
         run_len(1'b0, k);
         run_len(1'b1, k);
         @(posedge clk_i);
         #2;
      end
   endtask : conv

   task automatic test_done();
      if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done

   // Watchdog at 10000 cycles, well beyond the roughly one thousand cycles the tests need
   initial begin
      #400000;
      n_errors++;
      test_done();
   end

   initial begin
      n_errors = 0;
      total_checks = 0;
      rst_n_i = 1'b0;
      near_data = 8'h00;
      vis_data = 12'h000;
      ir_data = 12'h000;
      light_valid = 1'b0;
      repeat (6) @(posedge clk_i);
      #1;
      rst_n_i = 1'b1;
      // Reset values of every mapped place except the part identity at 0x00
      for (int i = 0; i < 10; i++) rchk(ra[i], rv[i]);
      // Each low config bit reaches its own output only
      for (int i = 0; i < 4; i++) begin
         lps_host_model_i.wr(ADDR_CFG, 8'(1 << i));
         chk({8'h00, led_drive_sel, light_sense_on, light_full_scale_sel, light_source_sel}, 12'(1 << i));
      end
      // Light window 0x100..0x800, persistence 4, AND combine
      lps_host_model_i.wr(ADDR_LTH_LO, 8'h00);
      lps_host_model_i.wr(ADDR_LTH_NIB, 8'h01);
      lps_host_model_i.wr(ADDR_LTH_HI, 8'h80);
      lps_host_model_i.wr(ADDR_IRQ, 8'h03);
      lps_host_model_i.wr(ADDR_CFG, 8'h04);
      repeat (3) lsamp(12'h100, 12'h7FF);
      rchk(ADDR_IRQ, 8'h03);
      rchk(ADDR_LRES_LO, 8'h00);
      rchk(ADDR_LRES_HI, 8'h01);
      lsamp(12'h100, 12'h7FF);
      chk({11'h000, irq_line}, 12'h001);
      rchk(ADDR_IRQ, 8'h0B);
      // Flag write of 1 ignored, OR combine; the host keeps bit 4 at zero
      lps_host_model_i.wr(ADDR_IRQ, 8'h0A);
      chk({11'h000, irq_line}, 12'h000);
      rchk(ADDR_IRQ, 8'h0A);
      lps_host_model_i.wr(ADDR_CFG, 8'h05);
      lsamp(12'h000, 12'h456);
      rchk(ADDR_LRES_LO, 8'h56);
      rchk(ADDR_LRES_HI, 8'h04);
      lps_host_model_i.wr(ADDR_IRQ, 8'h02);
      chk({11'h000, irq_line}, 12'h001);
      rchk(ADDR_IRQ, 8'h02);
      lps_host_model_i.wr(ADDR_CFG, 8'h01);
      lsamp(12'hABC, 12'hABC);
      rchk(ADDR_LRES_LO, 8'h56);
      // Proximity window 0x20..0x80, persistence 4, OR combine and then AND combine
      lps_host_model_i.wr(ADDR_NLOW, 8'h20);
      lps_host_model_i.wr(ADDR_NHIGH, 8'h80);
      lps_host_model_i.wr(ADDR_IRQ, 8'h20);
      near_data = 8'h80;
      lps_host_model_i.wr(ADDR_CFG, 8'hE4);
      conv(3);
      chk({11'h000, irq_line}, 12'h001);
      conv(1);
      chk({11'h000, irq_line}, 12'h000);
      rchk(ADDR_NRES, 8'h80);
      lps_host_model_i.wr(ADDR_IRQ, 8'hA1);
      chk({11'h000, irq_line}, 12'h001);
      lsamp(12'hFFF, 12'h000);
      chk({11'h000, irq_line}, 12'h000);
      near_data = 8'h20;
      conv(4);
      chk({11'h000, irq_line}, 12'h001);
      rchk(ADDR_IRQ, 8'h29);
      // Light persistence 8 and 16, OR combine; a miss first restarts the streak
      for (int s = 2; s < 4; s++) begin
         n = (s == 2) ? 8 : 16;
         lps_host_model_i.wr(ADDR_IRQ, {5'h00, 2'(s), 1'b0});
         lsamp(12'h456, 12'h000);
         repeat (n - 1) lsamp(12'hFFF, 12'h000);
         chk({11'h000, irq_line}, 12'h001);
         lsamp(12'hFFF, 12'h000);
         chk({11'h000, irq_line}, 12'h000);
      end
      // Conversion and sleep lengths for every sleep code
      for (int c = 0; c < 8; c++) begin
         lps_host_model_i.wr(ADDR_CFG, 8'h00);
         lps_host_model_i.wr(ADDR_CFG, {1'b1, 3'(c), 4'h0});
         run_len(1'b0, n);
         run_len(1'b1, n);
         if (c < 7) begin
            chk(12'(n), 12'(CONV_T));
            run_len(1'b0, n);
            chk(12'(n), 12'(slp[c] * UNIT_T));
         end else begin
            chk(12'(n), 12'h0C8);
         end
      end
      // Proximity off: no conversion at all; the abort needs one edge
      lps_host_model_i.wr(ADDR_CFG, 8'h00);
      @(posedge clk_i);
      #2;
      run_len(1'b0, n);
      chk(12'(n), 12'h0C8);
      test_done();
   end
endmodule : tb_top
